/* File: rxfmt_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module rxfmt_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // honest full and empty straight from the fill count
  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rp_r];

  // pointers wrap; depth is expected to be a power of two
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop) rp_r <= rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) mem[wp_r] <= in_data;
  end
endmodule : rxfmt_fifo
`default_nettype wire

/* File: rxfmt_framer.sv */
`timescale 1ns/1ps
`default_nettype none
module rxfmt_framer #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic api_output_select,
  // packet start: header captured when pkt_valid in idle, pkt_ready pulses a cycle later
  input wire logic pkt_valid,
  input wire rxfmt_pkg::rxfmt_hdr_t pkt_hdr,
  output logic pkt_ready,
  // payload bytes, pay_len of them per packet
  input wire logic [7:0] pay_data,
  input wire logic pay_valid,
  output logic pay_ready,
  // serial frame bytes toward the uart
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready
);
  // ****************************************
  // frame builder
  // ****************************************
  rxfmt_pkg::rxfmt_state_t st_r;
  rxfmt_pkg::rxfmt_state_t st_nxt;
  rxfmt_pkg::rxfmt_hdr_t hdr_r;
  logic expl_r;
  logic [4:0] pos_r;
  logic [15:0] left_r;
  logic [7:0] sum_r;
  logic [7:0] byte_c;
  logic emit;
  logic [7:0] f_data;
  logic f_ready;
  logic [15:0] len_field;
  logic [7:0] opt_byte;
  logic [4:0] hdr_last;
  logic [7:0] hdr_byte;
  logic [2:0] addr_idx;

  // mode is latched per packet so a change mid-frame cannot tear it
  assign len_field = (expl_r ? rxfmt_pkg::HDR_EXPL : rxfmt_pkg::HDR_BASIC) + hdr_r.pay_len;
  assign opt_byte = (hdr_r.acked ? rxfmt_pkg::OPT_ACK : 8'h00)
                  | (hdr_r.bcast ? rxfmt_pkg::OPT_BCAST : 8'h00);
  assign hdr_last = expl_r ? rxfmt_pkg::POS_OPT_E : rxfmt_pkg::POS_OPT_B;
  assign addr_idx = 3'(pos_r - rxfmt_pkg::POS_ADDR);

  // header byte selection by position
  always_comb begin
    hdr_byte = 8'h00;
    if (pos_r == rxfmt_pkg::POS_TYPE) begin
      hdr_byte = expl_r ? rxfmt_pkg::TYPE_EXPL : rxfmt_pkg::TYPE_BASIC;
    end else if (pos_r < rxfmt_pkg::POS_RSV0) begin
      hdr_byte = hdr_r.src_addr[8*(7-addr_idx) +: 8];
    end else if (pos_r == rxfmt_pkg::POS_RSV0) begin
      hdr_byte = rxfmt_pkg::RSVD_HI;
    end else if (pos_r == rxfmt_pkg::POS_RSV1) begin
      hdr_byte = rxfmt_pkg::RSVD_LO;
    end else if (pos_r == hdr_last) begin
      hdr_byte = opt_byte;
    end else if (pos_r == rxfmt_pkg::POS_SEP) begin
      hdr_byte = hdr_r.src_ep;
    end else if (pos_r == rxfmt_pkg::POS_DEP) begin
      hdr_byte = hdr_r.dst_ep;
    end else if (pos_r == rxfmt_pkg::POS_CL_HI) begin
      hdr_byte = hdr_r.cluster_id[15:8];
    end else if (pos_r == rxfmt_pkg::POS_CL_LO) begin
      hdr_byte = hdr_r.cluster_id[7:0];
    end else if (pos_r == rxfmt_pkg::POS_PR_HI) begin
      hdr_byte = hdr_r.profile_id[15:8];
    end else begin
      hdr_byte = hdr_r.profile_id[7:0];
    end
  end

  // byte offered to the fifo in each state
  always_comb begin
    byte_c = 8'h00;
    emit = 1'b0;
    case (st_r)
      rxfmt_pkg::RXFMT_START: begin
        byte_c = rxfmt_pkg::START_BYTE;
        emit = 1'b1;
      end
      rxfmt_pkg::RXFMT_LEN: begin
        byte_c = pos_r[0] ? len_field[15:8] : len_field[7:0];
        emit = 1'b1;
      end
      rxfmt_pkg::RXFMT_HDR: begin
        byte_c = hdr_byte;
        emit = 1'b1;
      end
      rxfmt_pkg::RXFMT_PAY: begin
        byte_c = pay_data;
        emit = pay_valid;
      end
      rxfmt_pkg::RXFMT_SUM: begin
        byte_c = rxfmt_pkg::CSUM_TARGET - sum_r;
        emit = 1'b1;
      end
      default: begin
        byte_c = 8'h00;
        emit = 1'b0;
      end
    endcase
  end

  wire step = emit && f_ready;
  assign pay_ready = (st_r == rxfmt_pkg::RXFMT_PAY) && f_ready;
  assign f_data = byte_c;

  // next state; fifo back-pressure holds every step
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      rxfmt_pkg::RXFMT_IDLE: if (pkt_valid) st_nxt = rxfmt_pkg::RXFMT_START;
      rxfmt_pkg::RXFMT_START: if (step) st_nxt = rxfmt_pkg::RXFMT_LEN;
      rxfmt_pkg::RXFMT_LEN: if (step && pos_r == 5'h02) st_nxt = rxfmt_pkg::RXFMT_HDR;
      rxfmt_pkg::RXFMT_HDR: begin
        if (step && pos_r == hdr_last) begin
          st_nxt = (hdr_r.pay_len == 16'h0000) ? rxfmt_pkg::RXFMT_SUM : rxfmt_pkg::RXFMT_PAY;
        end
      end
      rxfmt_pkg::RXFMT_PAY: if (step && left_r == 16'h0001) st_nxt = rxfmt_pkg::RXFMT_SUM;
      rxfmt_pkg::RXFMT_SUM: if (step) st_nxt = rxfmt_pkg::RXFMT_IDLE;
      default: st_nxt = rxfmt_pkg::RXFMT_IDLE;
    endcase
  end

  // pkt_ready is registered: one cycle pulse when the header is captured
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_r <= rxfmt_pkg::RXFMT_IDLE;
      pkt_ready <= 1'b0;
    end else begin
      st_r <= st_nxt;
      pkt_ready <= (st_r == rxfmt_pkg::RXFMT_IDLE) && pkt_valid && !pkt_ready;
    end
  end

  // header capture and position tracking
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hdr_r <= '0;
      expl_r <= 1'b0;
      pos_r <= 5'h00;
      left_r <= 16'h0000;
      sum_r <= 8'h00;
    end else if (st_r == rxfmt_pkg::RXFMT_IDLE) begin
      if (pkt_valid) begin
        hdr_r <= pkt_hdr;
        expl_r <= api_output_select;
        left_r <= pkt_hdr.pay_len;
      end
      pos_r <= 5'h00;
      sum_r <= 8'h00;
    end else if (step) begin
      if (pos_r != 5'h1F) pos_r <= pos_r + 5'h01;
      if (st_r == rxfmt_pkg::RXFMT_PAY) left_r <= left_r - 16'h0001;
      // sum runs from the type byte onward
      if (st_r == rxfmt_pkg::RXFMT_HDR || st_r == rxfmt_pkg::RXFMT_PAY) sum_r <= sum_r + byte_c;
    end
  end

  // LEN state emits high byte at pos 1 and low at pos 2
  // note pos_r[0] is 1 at position 1, 0 at position 2

  // ****************************************
  // output buffer
  // ****************************************
  logic [7:0] q_data;
  logic q_valid;
  logic q_ready;

  rxfmt_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .srst(srst),
    .in_data(f_data),
    .in_valid(emit),
    .in_ready(f_ready),
    .out_data(q_data),
    .out_valid(q_valid),
    .out_ready(q_ready)
  );

  // registered output stage so tx_data and tx_valid leave a flip-flop
  assign q_ready = !tx_valid || tx_ready;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
    end else if (q_ready) begin
      tx_valid <= q_valid;
      // data moves only with a real byte, so an unwritten fifo slot never reaches the pins
      if (q_valid) tx_data <= q_data;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  chk_start_byte: assert property (@(posedge ref_clk) disable iff (srst)
    (st_r == rxfmt_pkg::RXFMT_START && step) |-> f_data == 8'h7E)
    else $error("start byte wrong");
  chk_len_hi_first: assert property (@(posedge ref_clk) disable iff (srst)
    (st_r == rxfmt_pkg::RXFMT_LEN && step && pos_r == 5'h01) |-> f_data == len_field[15:8])
    else $error("length high byte wrong");
  chk_checksum_sum: assert property (@(posedge ref_clk) disable iff (srst)
    (st_r == rxfmt_pkg::RXFMT_SUM && step) |-> 8'(sum_r + f_data) == 8'hFF)
    else $error("checksum does not sum to ff");
  chk_type_mode: assert property (@(posedge ref_clk) disable iff (srst)
    (st_r == rxfmt_pkg::RXFMT_HDR && pos_r == 5'h03) |-> f_data == (expl_r ? 8'h91 : 8'h90))
    else $error("type byte does not match mode");
  chk_type_basic: assert property (@(posedge ref_clk) disable iff (srst)
    (st_r == rxfmt_pkg::RXFMT_IDLE && pkt_valid && !api_output_select) |=> !expl_r)
    else $error("basic mode not latched");
  chk_rsvd_bytes: assert property (@(posedge ref_clk) disable iff (srst)
    (st_r == rxfmt_pkg::RXFMT_HDR && step && pos_r == 5'h0C) |=> f_data == 8'hFE)
    else $error("reserved bytes wrong");
  chk_opt_bits: assert property (@(posedge ref_clk) disable iff (srst)
    (st_r == rxfmt_pkg::RXFMT_HDR && pos_r == hdr_last) |-> f_data[1] == hdr_r.bcast && f_data[0] == hdr_r.acked)
    else $error("receive options wrong");
  chk_pay_order: assert property (@(posedge ref_clk) disable iff (srst)
    (st_r == rxfmt_pkg::RXFMT_HDR && step && pos_r == hdr_last && hdr_r.pay_len != 16'h0000)
      |=> st_r == rxfmt_pkg::RXFMT_PAY && pos_r == hdr_last + 5'h01)
    else $error("payload not after options");

  // length low byte, worked out again from the layout sizes
  chk_len_lo_value: assert property (@(posedge ref_clk) disable iff (srst)
    (st_r == rxfmt_pkg::RXFMT_LEN && pos_r == 5'h02) |-> f_data == 8'(hdr_r.pay_len + (expl_r ? 16'h0012 : 16'h000C)))
    else $error("length low byte wrong");
  // basic frames carry the plain receive type
  chk_type_basic_val: assert property (@(posedge ref_clk) disable iff (srst)
    (st_r == rxfmt_pkg::RXFMT_HDR && pos_r == rxfmt_pkg::POS_TYPE && !expl_r) |-> f_data == 8'h90)
    else $error("basic type byte wrong");
  // explicit mode must be latched with the header
  chk_expl_latch: assert property (@(posedge ref_clk) disable iff (srst)
    (st_r == rxfmt_pkg::RXFMT_IDLE && pkt_valid && api_output_select) |=> expl_r)
    else $error("explicit mode not latched");
  // basic header ends at the options byte, no endpoint fields follow
  chk_basic_hdr_end: assert property (@(posedge ref_clk) disable iff (srst)
    (st_r == rxfmt_pkg::RXFMT_HDR && step && !expl_r && pos_r == 5'h0E) |=> st_r != rxfmt_pkg::RXFMT_HDR)
    else $error("basic header too long");

  // sender address, first and last byte, and the first reserved byte
  chk_addr_first: assert property (@(posedge ref_clk) disable iff (srst)
    (st_r == rxfmt_pkg::RXFMT_HDR && pos_r == 5'h04) |-> f_data == hdr_r.src_addr[63:56])
    else $error("address high byte wrong");
  chk_addr_last: assert property (@(posedge ref_clk) disable iff (srst)
    (st_r == rxfmt_pkg::RXFMT_HDR && pos_r == 5'h0B) |-> f_data == hdr_r.src_addr[7:0])
    else $error("address low byte wrong");
  chk_rsvd_first: assert property (@(posedge ref_clk) disable iff (srst)
    (st_r == rxfmt_pkg::RXFMT_HDR && pos_r == 5'h0C) |-> f_data == 8'hFF)
    else $error("first reserved byte wrong");

  // options byte in each layout: ack bit matches acked, unused bits clear
  chk_opt_basic: assert property (@(posedge ref_clk) disable iff (srst)
    (st_r == rxfmt_pkg::RXFMT_HDR && !expl_r && pos_r == 5'h0E)
      |-> f_data[7:2] == 6'h00 && f_data[0] == hdr_r.acked)
    else $error("basic options byte wrong");
  chk_opt_expl: assert property (@(posedge ref_clk) disable iff (srst)
    (st_r == rxfmt_pkg::RXFMT_HDR && expl_r && pos_r == 5'h14)
      |-> f_data[7:2] == 6'h00 && f_data[0] == hdr_r.acked)
    else $error("explicit options byte wrong");

  // explicit addressing fields
  chk_src_ep: assert property (@(posedge ref_clk) disable iff (srst)
    (st_r == rxfmt_pkg::RXFMT_HDR && expl_r && pos_r == 5'h0E) |-> f_data == hdr_r.src_ep)
    else $error("source endpoint wrong");
  chk_dst_ep: assert property (@(posedge ref_clk) disable iff (srst)
    (st_r == rxfmt_pkg::RXFMT_HDR && expl_r && pos_r == 5'h0F) |-> f_data == hdr_r.dst_ep)
    else $error("destination endpoint wrong");
  chk_cluster_hi: assert property (@(posedge ref_clk) disable iff (srst)
    (st_r == rxfmt_pkg::RXFMT_HDR && expl_r && pos_r == 5'h10) |-> f_data == hdr_r.cluster_id[15:8])
    else $error("cluster high byte wrong");
  chk_cluster_lo: assert property (@(posedge ref_clk) disable iff (srst)
    (st_r == rxfmt_pkg::RXFMT_HDR && expl_r && pos_r == 5'h11) |-> f_data == hdr_r.cluster_id[7:0])
    else $error("cluster low byte wrong");
  chk_profile_hi: assert property (@(posedge ref_clk) disable iff (srst)
    (st_r == rxfmt_pkg::RXFMT_HDR && expl_r && pos_r == 5'h12) |-> f_data == hdr_r.profile_id[15:8])
    else $error("profile high byte wrong");
  chk_profile_lo: assert property (@(posedge ref_clk) disable iff (srst)
    (st_r == rxfmt_pkg::RXFMT_HDR && expl_r && pos_r == 5'h13) |-> f_data == hdr_r.profile_id[7:0])
    else $error("profile low byte wrong");

  // the last payload byte hands over to the checksum, and the checksum closes the frame
  chk_pay_count: assert property (@(posedge ref_clk) disable iff (srst)
    (st_r == rxfmt_pkg::RXFMT_PAY && step && left_r == 16'h0001) |=> st_r == rxfmt_pkg::RXFMT_SUM)
    else $error("payload count wrong");
  chk_sum_closes: assert property (@(posedge ref_clk) disable iff (srst)
    (st_r == rxfmt_pkg::RXFMT_SUM && step) |=> st_r == rxfmt_pkg::RXFMT_IDLE)
    else $error("frame not closed after checksum");
endmodule : rxfmt_framer
`default_nettype wire

/* File: rxfmt_framer_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// bench for the receive frame formatter
// ****************************************
module rxfmt_framer_tb_top;
  logic ref_clk, srst, mode, pkt_valid, pkt_ready, pay_valid, pay_ready, tx_valid, tx_ready, slow;
  logic [7:0] pay_data, tx_data;
  rxfmt_pkg::rxfmt_hdr_t hdr;
  int error_cnt, checks_done, cyc, base;
  logic [7:0] exp[$];
  int lens[$];
  logic [7:0] s;

  rxfmt_framer #(.FIFO_DEPTH(8)) dut (.ref_clk(ref_clk), .srst(srst), .api_output_select(mode),
    .pkt_valid(pkt_valid), .pkt_hdr(hdr), .pkt_ready(pkt_ready), .pay_data(pay_data),
    .pay_valid(pay_valid), .pay_ready(pay_ready), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready));
  rxfmt_host host (.ref_clk(ref_clk), .srst(srst), .slow(slow), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready));

  // expected frame, built from the field layout and appended to the queue
  function automatic void mk(input rxfmt_pkg::rxfmt_hdr_t h, input logic m, input logic [7:0] p[$],
                             inout logic [7:0] q[$]);
    logic [7:0] f[$];
    logic [15:0] n;
    logic [7:0] sum;
    n = (m ? 16'h0012 : 16'h000C) + h.pay_len;
    f = {8'h7E, n[15:8], n[7:0], m ? 8'h91 : 8'h90};
    for (int k = 7; k >= 0; k--) f.push_back(h.src_addr[k*8 +: 8]);
    f = {f, 8'hFF, 8'hFE};
    if (m) f = {f, h.src_ep, h.dst_ep, h.cluster_id[15:8], h.cluster_id[7:0], h.profile_id[15:8],
                h.profile_id[7:0]};
    f.push_back({6'h00, h.bcast, h.acked});
    f = {f, p};
    sum = 8'h00;
    for (int k = 3; k < f.size(); k++) sum += f[k];
    f.push_back(8'hFF - sum);
    q = {q, f};
  endfunction : mk

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
    checks_done++;
    if (seen !== want) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, want, seen);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  // one packet: header handshake, then exactly pay_len payload bytes
  task automatic send(input logic m, input logic a, input logic b, input int len);
    rxfmt_pkg::rxfmt_hdr_t h;
    logic [7:0] p[$];
    h.src_addr = {$urandom, $urandom};
    h.src_ep = 8'($urandom);
    h.dst_ep = 8'($urandom);
    h.cluster_id = 16'($urandom);
    h.profile_id = 16'($urandom);
    h.acked = a;
    h.bcast = b;
    h.pay_len = 16'(len);
    for (int k = 0; k < len; k++) p.push_back(8'($urandom));
    mk(h, m, p, exp);
    lens.push_back((m ? 22 : 16) + len);
    mode = m;
    hdr = h;
    pkt_valid = 1'b1;
    do begin
      @(posedge ref_clk);
      #1;
    end while (pkt_ready !== 1'b1);
    pkt_valid = 1'b0;
    foreach (p[k]) begin
      pay_data = p[k];
      pay_valid = 1'b1;
      while (pay_ready !== 1'b1) begin
        @(posedge ref_clk);
        #1;
      end
      @(posedge ref_clk);
      #1;
    end
    pay_valid = 1'b0;
  endtask : send

  // ****************************************
  // clock, hang limit and main sequence
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // about 1300 cycles are needed; the limit leaves wide margin
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end

  initial begin
    srst = 1'b1;
    mode = 1'b0;
    pkt_valid = 1'b0;
    hdr = '0;
    pay_data = 8'h00;
    pay_valid = 1'b0;
    slow = 1'b0;
    void'($urandom(32'h5C4068E9));
    repeat (12) @(posedge ref_clk);
    #1;
    srst = 1'b0;
    // corners first (empty and short payloads), then random lengths from 0 to 24, reaching past the fifo depth
    for (int i = 0; i < 16; i++) begin
      slow = (i >= 8);
      send(i[0], i[1], i[2], (i < 4) ? i : $urandom_range(0, 24));
    end
    while (host.got.size() < exp.size()) @(posedge ref_clk);
    repeat (20) @(posedge ref_clk);
    check("byte count", 16'(host.got.size()), 16'(exp.size()));
    base = 0;
    foreach (lens[f]) begin
      s = 8'h00;
      for (int k = 0; k < lens[f]; k++) begin
        check("frame byte", {8'h00, host.got[base+k]}, {8'h00, exp[base+k]});
        if (k >= 3) s += host.got[base+k];
      end
      check("checksum sum", {8'h00, s}, 16'h00FF);
      base += lens[f];
    end
    finish_test();
  end
endmodule : rxfmt_framer_tb_top
`default_nettype wire

/* File: rxfmt_host.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// host side of the uart frame byte stream
// ****************************************
module rxfmt_host (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic slow,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready
);
  logic [7:0] got[$];

  // random back-pressure while slow, so the framer's fifo really fills up
  initial begin
    tx_ready = 1'b0;
    forever begin
      @(posedge ref_clk);
      #1;
      tx_ready = slow ? ($urandom_range(0, 3) == 0) : 1'b1;
    end
  end

  // keep every accepted byte; the bench checks framing and the sum over it
  always @(posedge ref_clk) begin
    if (!srst && tx_valid && tx_ready) begin
      got.push_back(tx_data);
    end
  end
endmodule : rxfmt_host
`default_nettype wire

/* File: rxfmt_pkg.sv */
package rxfmt_pkg;
  localparam logic [7:0] START_BYTE = 8'h7E;
  localparam logic [7:0] TYPE_BASIC = 8'h90;
  localparam logic [7:0] TYPE_EXPL = 8'h91;
  localparam logic [7:0] RSVD_HI = 8'hFF;
  localparam logic [7:0] RSVD_LO = 8'hFE;
  localparam logic [7:0] CSUM_TARGET = 8'hFF;
  localparam logic [7:0] OPT_ACK = 8'h01;
  localparam logic [7:0] OPT_BCAST = 8'h02;
  // header bytes from the type byte through the options byte
  localparam logic [15:0] HDR_BASIC = 16'h000C;
  localparam logic [15:0] HDR_EXPL = 16'h0012;
  // field positions within the frame
  localparam logic [4:0] POS_TYPE = 5'h03;
  localparam logic [4:0] POS_ADDR = 5'h04;
  localparam logic [4:0] POS_RSV0 = 5'h0C;
  localparam logic [4:0] POS_RSV1 = 5'h0D;
  localparam logic [4:0] POS_OPT_B = 5'h0E;
  localparam logic [4:0] POS_SEP = 5'h0E;
  localparam logic [4:0] POS_DEP = 5'h0F;
  localparam logic [4:0] POS_CL_HI = 5'h10;
  localparam logic [4:0] POS_CL_LO = 5'h11;
  localparam logic [4:0] POS_PR_HI = 5'h12;
  localparam logic [4:0] POS_PR_LO = 5'h13;
  localparam logic [4:0] POS_OPT_E = 5'h14;

  // packet descriptor handed in with each received packet
  typedef struct packed {
    logic [63:0] src_addr;
    logic [7:0] src_ep;
    logic [7:0] dst_ep;
    logic [15:0] cluster_id;
    logic [15:0] profile_id;
    logic acked;
    logic bcast;
    logic [15:0] pay_len;
  } rxfmt_hdr_t;

  typedef enum logic [5:0] {
    RXFMT_IDLE = 6'b000001,
    RXFMT_LEN = 6'b000010,
    RXFMT_HDR = 6'b000100,
    RXFMT_PAY = 6'b001000,
    RXFMT_SUM = 6'b010000,
    RXFMT_START = 6'b100000
  } rxfmt_state_t;
endpackage : rxfmt_pkg
